// ==== ebca_pkg.sv ====
// shared types and constants of the external bus control and arbitration block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package ebca_pkg;

  localparam int EBCA_WS_W = 5;
  localparam int EBCA_REGIONS = 4;
  localparam int EBCA_SEL_W = 2;
  localparam int EBCA_SEL_LSB = 30;
  localparam int EBCA_BEAT_W = 2;
  localparam int EBCA_BEAT_LSB = 2;

  typedef struct packed {
    logic [EBCA_WS_W-1:0] read_first_wait_count;
    logic [EBCA_WS_W-1:0] read_next_wait_count;
    logic [EBCA_WS_W-1:0] write_first_wait_count;
    logic [EBCA_WS_W-1:0] write_next_wait_count;
    logic [EBCA_WS_W-1:0] turnaround_wait_count;
    logic ready_en;
    logic burst_break_en;
    logic pipelined;
  } ebca_region_type;

  typedef struct packed {
    logic [31:0] addr;
    logic read;
    logic data;
    logic dma;
    logic priv;
    logic locked;
    logic lock_last;
    logic [EBCA_BEAT_W-1:0] beats;
  } ebca_req_type;

  typedef enum logic [2:0] {
    EBCA_IDLE,
    EBCA_ADDR,
    EBCA_DATA,
    EBCA_TURN,
    EBCA_HOLD,
    EBCA_YIELD
  } ebca_state_type;

  localparam logic [EBCA_WS_W-1:0] EBCA_CNT_ZERO = 5'h00;
  localparam logic [EBCA_WS_W-1:0] EBCA_CNT_ONE = 5'h01;
  localparam logic [EBCA_BEAT_W-1:0] EBCA_BEAT_ONE = 2'h1;

  function automatic logic [EBCA_WS_W-1:0] ebca_wait_count(input ebca_region_type r, input logic rd,
                                                            input logic first);
    if (rd) begin
      ebca_wait_count = first ? r.read_first_wait_count : r.read_next_wait_count;
    end else begin
      ebca_wait_count = first ? r.write_first_wait_count : r.write_next_wait_count;
    end
  endfunction : ebca_wait_count

endpackage : ebca_pkg

// ==== ebca_region_sel.sv ====
// region lookup: picks a region's wait and enable settings by address
`timescale 1ns/1ps
module ebca_region_sel
  import ebca_pkg::*;
(
  input wire logic [31:0] addr_in,
  input ebca_region_type region_cfg_in [EBCA_REGIONS],
  output ebca_region_type region_out
);

  always_comb begin
    region_out = region_cfg_in[addr_in[EBCA_SEL_LSB +: EBCA_SEL_W]];
  end

endmodule : ebca_region_sel

// ==== ebca_bus_ctrl.sv ====
// external bus control: transfer termination, strobes, transceiver control, lock and arbitration
//
`timescale 1ns/1ps
module ebca_bus_ctrl
  import ebca_pkg::*;
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input ebca_region_type region_cfg_in [EBCA_REGIONS],
  input wire logic req_valid_in,
  input ebca_req_type req_in,
  output logic req_accept_out,
  output logic req_done_out,
  input wire logic ready_in,
  input wire logic burst_break_input_in,
  input wire logic hold_in,
  input wire logic bus_yield_input_in,
  input wire logic cpu_reset_in,
  output logic [31:0] addr_out,
  output logic address_strobe_out,
  output logic write_read_out,
  output logic wait_out,
  output logic final_transfer_flag_out,
  output logic transceiver_direction_out,
  output logic data_phase_enable_out,
  output logic lock_out,
  output logic bus_grant_ack_out,
  output logic pending_request_out,
  output logic data_or_code_out,
  output logic dma_out,
  output logic privileged_access_out,
  output logic bus_drive_out
);

  typedef struct packed {
    ebca_state_type st;
    logic rdy_m;
    logic rdy_s;
    logic bt_m;
    logic bt_s;
    logic hold_m;
    logic hold_s;
    logic yld_m;
    logic yld_s;
    logic crst_m;
    logic crst_s;
    ebca_req_type req;
    logic [EBCA_WS_W-1:0] cnt;
    logic [EBCA_BEAT_W-1:0] beat;
    logic strb;
    logic wt;
    logic fin;
    logic dtr;
    logic dpe;
    logic lock;
    logic gack;
    logic pend;
    logic wr;
    logic dc;
    logic dma;
    logic priv;
    logic drive;
    logic accept;
    logic done;
  } ebca_bus_state_type;

  ebca_bus_state_type state_q;
  ebca_bus_state_type state_d;
  ebca_region_type cur_region;
  ebca_region_type new_region;

  ebca_region_sel u_cur_region (
    .addr_in(state_q.req.addr),
    .region_cfg_in(region_cfg_in),
    .region_out(cur_region)
  );

  ebca_region_sel u_new_region (
    .addr_in(req_in.addr),
    .region_cfg_in(region_cfg_in),
    .region_out(new_region)
  );

  logic brk;
  logic beat_end;
  logic last_beat;
  logic take;
  logic keep_dpe;
  logic finish;

  always_comb begin
    state_d = state_q;
    take = 1'b0;
    keep_dpe = 1'b0;
    finish = 1'b0;
    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    state_d.rdy_m = ready_in;
    state_d.rdy_s = state_q.rdy_m;
    state_d.bt_m = burst_break_input_in;
    state_d.bt_s = state_q.bt_m;
    state_d.hold_m = hold_in;
    state_d.hold_s = state_q.hold_m;
    state_d.yld_m = bus_yield_input_in;
    state_d.yld_s = state_q.yld_m;
    state_d.crst_m = cpu_reset_in;
    state_d.crst_s = state_q.crst_m;
    state_d.strb = 1'b0;
    state_d.accept = 1'b0;
    state_d.done = 1'b0;

    // ------------------------------------------------------------------------
    // termination decode
    // ------------------------------------------------------------------------
    brk = cur_region.ready_en & cur_region.burst_break_en & state_q.bt_s;
    beat_end = !cur_region.ready_en || state_q.rdy_s || brk;
    last_beat = state_q.beat == state_q.req.beats;

    // ------------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------------
    case (state_q.st)
      EBCA_IDLE: begin
        if (state_q.hold_s) begin
          state_d.st = EBCA_HOLD;
        end else if (!state_q.crst_s && req_valid_in) begin
          take = 1'b1;
        end
      end
      EBCA_ADDR: begin
        if (state_q.yld_s) begin
          state_d.st = EBCA_YIELD;
        end else begin
          state_d.cnt = ebca_wait_count(cur_region, state_q.req.read, 1'b1);
          state_d.st = EBCA_DATA;
        end
      end
      EBCA_DATA: begin
        if (state_q.yld_s) begin
          state_d.st = EBCA_YIELD;
        end else if (state_q.cnt != EBCA_CNT_ZERO) begin
          state_d.cnt = state_q.cnt - EBCA_CNT_ONE;
        end else if (beat_end) begin
          if (last_beat) begin
            finish = 1'b1;
          end else begin
            state_d.beat = state_q.beat + EBCA_BEAT_ONE;
            state_d.req.addr[EBCA_BEAT_LSB +: EBCA_BEAT_W] =
              state_q.req.addr[EBCA_BEAT_LSB +: EBCA_BEAT_W] + EBCA_BEAT_ONE;
            if (brk) begin
              state_d.st = EBCA_ADDR;
              state_d.strb = 1'b1;
            end else begin
              state_d.cnt = ebca_wait_count(cur_region, state_q.req.read, 1'b0);
            end
          end
        end
      end
      EBCA_TURN: begin
        if (state_q.cnt == EBCA_CNT_ONE) begin
          state_d.st = EBCA_IDLE;
        end else begin
          state_d.cnt = state_q.cnt - EBCA_CNT_ONE;
        end
      end
      EBCA_HOLD: begin
        if (!state_q.hold_s) begin
          state_d.st = EBCA_IDLE;
        end
      end
      EBCA_YIELD: begin
        if (!state_q.yld_s) begin
          state_d.st = EBCA_ADDR;
          state_d.strb = 1'b1;
        end
      end
      default: begin
        state_d.st = EBCA_IDLE;
      end
    endcase

    // ------------------------------------------------------------------------
    // end of access and pipelined follow-on
    // ------------------------------------------------------------------------
    if (finish) begin
      state_d.done = 1'b1;
      if (state_q.req.lock_last) begin
        state_d.lock = 1'b0;
      end
      if (cur_region.turnaround_wait_count != EBCA_CNT_ZERO) begin
        state_d.st = EBCA_TURN;
        state_d.cnt = cur_region.turnaround_wait_count;
      end else if (!state_q.hold_s && !state_q.crst_s && req_valid_in && state_q.req.read &&
                   cur_region.pipelined && req_in.read && new_region.pipelined) begin
        take = 1'b1;
        keep_dpe = 1'b1;
      end else begin
        state_d.st = EBCA_IDLE;
      end
    end

    if (take) begin
      state_d.req = req_in;
      state_d.beat = '0;
      state_d.accept = 1'b1;
      state_d.st = EBCA_ADDR;
      state_d.strb = 1'b1;
      state_d.wr = req_in.read;
      state_d.dc = req_in.data;
      state_d.dma = req_in.dma;
      state_d.priv = req_in.priv;
      if (!state_q.dpe) begin
        state_d.dtr = req_in.read;
      end
      if (req_in.locked) begin
        state_d.lock = 1'b1;
      end
    end

    // ------------------------------------------------------------------------
    // device reset: bus idles, hold still honoured
    // ------------------------------------------------------------------------
    if (state_q.crst_s && state_q.st != EBCA_HOLD) begin
      state_d.st = state_q.hold_s ? EBCA_HOLD : EBCA_IDLE;
      state_d.strb = 1'b0;
      state_d.lock = 1'b0;
      state_d.accept = 1'b0;
      state_d.done = 1'b0;
      take = 1'b0;
      keep_dpe = 1'b0;
    end

    // ------------------------------------------------------------------------
    // outputs from next state
    // ------------------------------------------------------------------------
    state_d.wt = state_d.st == EBCA_DATA && state_d.cnt != EBCA_CNT_ZERO;
    state_d.fin = state_d.st == EBCA_DATA && state_d.cnt == EBCA_CNT_ZERO &&
                  state_d.beat == state_d.req.beats;
    state_d.dpe = state_d.st == EBCA_DATA || keep_dpe;
    state_d.gack = state_d.st == EBCA_HOLD;
    state_d.drive = state_d.st != EBCA_HOLD && state_d.st != EBCA_YIELD;
    // a request already accepted is no longer waiting
    state_d.pend = req_valid_in && !take && !state_q.accept;
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign addr_out = state_q.req.addr;
  assign address_strobe_out = state_q.strb;
  assign write_read_out = state_q.wr;
  assign wait_out = state_q.wt;
  assign final_transfer_flag_out = state_q.fin;
  assign transceiver_direction_out = state_q.dtr;
  assign data_phase_enable_out = state_q.dpe;
  assign lock_out = state_q.lock;
  assign bus_grant_ack_out = state_q.gack;
  assign pending_request_out = state_q.pend;
  assign data_or_code_out = state_q.dc;
  assign dma_out = state_q.dma;
  assign privileged_access_out = state_q.priv;
  assign bus_drive_out = state_q.drive;
  assign req_accept_out = state_q.accept;
  assign req_done_out = state_q.done;

endmodule : ebca_bus_ctrl

// ==== ebca_bus_ctrl_properties.sv ====
// assertions on the bus control ports
`timescale 1ns/1ps
module ebca_bus_ctrl_properties
  import ebca_pkg::*;
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic hold_in,
  input wire logic req_done_out,
  input wire logic address_strobe_out,
  input wire logic write_read_out,
  input wire logic wait_out,
  input wire logic final_transfer_flag_out,
  input wire logic transceiver_direction_out,
  input wire logic data_phase_enable_out,
  input wire logic bus_grant_ack_out,
  input wire logic data_or_code_out,
  input wire logic bus_drive_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  strobe_one_clk_a: assert property (address_strobe_out |=> !address_strobe_out)
    else $error("strobe held past one clock");
  wait_internal_a: assert property (wait_out |-> data_phase_enable_out && !final_transfer_flag_out)
    else $error("wait outside internal counting");
  dir_den_low_a: assert property ($changed(transceiver_direction_out) |-> !data_phase_enable_out)
    else $error("direction changed while enabled");
  grant_float_a: assert property (bus_grant_ack_out |-> !bus_drive_out)
    else $error("bus driven while granted");
  final_to_done_a: assert property ($fell(final_transfer_flag_out) && bus_drive_out |-> req_done_out)
    else $error("final flag dropped before termination");
  grant_after_hold_a: assert property ($rose(bus_grant_ack_out) |-> $past(hold_in, 3))
    else $error("grant without hold");
  rw_with_strobe_a: assert property ($changed(write_read_out) |-> address_strobe_out)
    else $error("read/write moved off strobe");
  dc_with_strobe_a: assert property ($changed(data_or_code_out) |-> address_strobe_out)
    else $error("data/code moved off strobe");
  cover property (final_transfer_flag_out ##1 req_done_out);
  cover property ($rose(bus_grant_ack_out));
  cover property ($fell(bus_drive_out) && !bus_grant_ack_out);
  cover property (data_phase_enable_out && address_strobe_out);
endmodule : ebca_bus_ctrl_properties

bind ebca_bus_ctrl ebca_bus_ctrl_properties ebca_bus_ctrl_properties_inst (.mclk_in, .arst_n_in, .hold_in,
  .req_done_out, .address_strobe_out, .write_read_out, .wait_out, .final_transfer_flag_out,
  .transceiver_direction_out, .data_phase_enable_out, .bus_grant_ack_out, .data_or_code_out, .bus_drive_out);

// ==== ebca_mem_model.sv ====
// far side memory: answers each data beat with ready, plus burst break on the first beat after arming
`timescale 1ns/1ps
module ebca_mem_model (
  input wire logic mclk_in,
  input wire logic strobe_in,
  input wire logic dpe_in,
  input wire logic wait_in,
  input wire logic [3:0] lat_in,
  input wire logic arm_in,
  output logic ready_out,
  output logic break_out
);
  logic [3:0] cnt_q = 4'h0;
  logic armed_q = 1'b0;
  initial ready_out = 1'b0;
  initial break_out = 1'b0;
  always @(posedge mclk_in) begin
    ready_out <= 1'b0;
    break_out <= 1'b0;
    if (arm_in) armed_q <= 1'b1;
    if (strobe_in || !dpe_in || wait_in) cnt_q <= 4'h0;
    else if (cnt_q == lat_in) begin
      cnt_q <= 4'h0;
      ready_out <= 1'b1;
      break_out <= armed_q;
      armed_q <= 1'b0;
    end else cnt_q <= cnt_q + 4'h1;
  end
endmodule : ebca_mem_model

// ==== ebca_bus_ctrl_test.sv ====
// self-checking bench for the bus control block
`timescale 1ns/1ps
module ebca_bus_ctrl_test
  import ebca_pkg::*;
;
  logic mclk_in = 0, arst_n_in = 0, req_valid_in = 0, hold_in = 0, bus_yield_input_in = 0, cpu_reset_in = 0;
  logic arm = 0, lk = 0, ll = 0;
  logic [3:0] lat = 4'h0;
  ebca_region_type cfg [EBCA_REGIONS];
  ebca_req_type req_in = '0;
  logic req_accept_out, req_done_out, ready_in, burst_break_input_in, address_strobe_out, write_read_out;
  logic wait_out, final_transfer_flag_out, transceiver_direction_out, data_phase_enable_out, lock_out;
  logic bus_grant_ack_out, pending_request_out, data_or_code_out, dma_out, privileged_access_out, bus_drive_out;
  logic [31:0] addr_out;
  int bad_count = 0, num_checks = 0, cyc, ns, c0, ticks = 0, nw, nf, nd, na;
  always #2.5 mclk_in = ~mclk_in;
  ebca_bus_ctrl ebca_bus_ctrl_inst (.mclk_in, .arst_n_in, .region_cfg_in(cfg), .req_valid_in, .req_in,
    .req_accept_out, .req_done_out, .ready_in, .burst_break_input_in, .hold_in, .bus_yield_input_in,
    .cpu_reset_in, .addr_out, .address_strobe_out, .write_read_out, .wait_out, .final_transfer_flag_out,
    .transceiver_direction_out, .data_phase_enable_out, .lock_out, .bus_grant_ack_out, .pending_request_out,
    .data_or_code_out, .dma_out, .privileged_access_out, .bus_drive_out);
  ebca_mem_model ebca_mem_model_inst (.mclk_in, .strobe_in(address_strobe_out), .dpe_in(data_phase_enable_out),
    .wait_in(wait_out), .lat_in(lat), .arm_in(arm), .ready_out(ready_in), .break_out(burst_break_input_in));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic go(input logic [31:0] a, input logic [3:0] f, input logic [1:0] nb);
    int n;
    n = 0;
    @(posedge mclk_in);
    req_valid_in <= 1'b1;
    req_in <= '{a, f[0], f[1], f[2], f[3], lk, ll, nb};
    do @(negedge mclk_in); while (req_accept_out !== 1'b1 && ++n < 60);
    chk({write_read_out, data_or_code_out, dma_out, privileged_access_out, transceiver_direction_out},
      {f[0], f[1], f[2], f[3], f[0]}, "qual");
    na = n;
    ns = address_strobe_out;
    nw = 0;
    nf = 0;
    nd = 0;
    cyc = 0;
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
    do begin
      @(negedge mclk_in);
      cyc++;
      ns += address_strobe_out;
      nw += wait_out;
      nf += final_transfer_flag_out;
      nd += data_phase_enable_out;
    end while (req_done_out !== 1'b1 && ++n < 200);
    chk(addr_out[3:2], nb, "beat");
  endtask : go
  task automatic grant();
    int n;
    n = 0;
    do @(negedge mclk_in); while (bus_grant_ack_out !== 1'b1 && ++n < 12);
    chk(bus_grant_ack_out, 1'b1, "ack");
    chk(bus_drive_out, 1'b0, "float");
  endtask : grant
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  always @(posedge mclk_in) if (++ticks == 20000) begin
    bad_count++;
    stop_test();
  end
  initial begin
    for (int i = 0; i < EBCA_REGIONS; i++) cfg[i] = '0;
    cfg[0].read_first_wait_count = 5'h01;
    cfg[0].write_first_wait_count = 5'h01;
    cfg[0].turnaround_wait_count = 5'h03;
    cfg[3].pipelined = 1'b1;
    cfg[1].ready_en = 1'b1;
    cfg[2] = cfg[1];
    cfg[2].burst_break_en = 1'b1;
    repeat (20) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    for (int i = 0; i < 16; i++) begin
      go(32'h00000000, i[3:0], 2'h0);
      chk(cyc, 3, "length");
      chk(nw, 1, "waits");
      chk(nf, 1, "final");
      chk(nd, 2, "enable");
      if (i > 0) chk(na, 3, "turnaround");
    end
    $display("test plain done");
    go(32'h40000000, 4'h1, 2'h3);
    c0 = cyc;
    chk(ns, 1, "strobes");
    lat <= 4'h9;
    go(32'h40000000, 4'h1, 2'h3);
    chk(cyc >= c0 + 8, 1'b1, "slow");
    chk(nw, 0, "ext wait");
    chk(nf > 4, 1'b1, "final held");
    $display("test ready done");
    lat <= 4'h2;
    arm <= 1'b1;
    @(posedge mclk_in);
    arm <= 1'b0;
    go(32'h80000000, 4'h1, 2'h3);
    chk(ns, 2, "split");
    $display("test break done");
    fork
      go(32'hC0000000, 4'h1, 2'h0);
      begin
        do @(negedge mclk_in); while (req_accept_out !== 1'b1);
        @(negedge mclk_in);
        req_valid_in <= 1'b1;
        req_in <= '{32'hC0000000, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0};
      end
    join
    chk({data_phase_enable_out, req_accept_out, address_strobe_out}, 3'h7, "pipelined");
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
    @(negedge mclk_in);
    chk(data_phase_enable_out, 1'b1, "pipe enable");
    @(negedge mclk_in);
    chk(req_done_out, 1'b1, "pipe done");
    $display("test pipeline done");
    lat <= 4'h9;
    fork
      go(32'h40000000, 4'h1, 2'h0);
      begin
        repeat (4) @(posedge mclk_in);
        bus_yield_input_in <= 1'b1;
        repeat (4) @(negedge mclk_in);
        chk(bus_drive_out, 1'b0, "yield");
        @(posedge mclk_in);
        bus_yield_input_in <= 1'b0;
      end
    join
    chk(ns, 2, "resume");
    $display("test yield done");
    lk = 1'b1;
    go(32'h00000000, 4'h3, 2'h0);
    chk(lock_out, 1'b1, "lock");
    hold_in <= 1'b1;
    grant();
    ll = 1'b1;
    fork
      go(32'h00000000, 4'h3, 2'h0);
      begin
        repeat (4) @(negedge mclk_in);
        chk(pending_request_out, 1'b1, "pending");
        chk(lock_out, 1'b1, "lock held");
        @(posedge mclk_in);
        hold_in <= 1'b0;
      end
    join
    repeat (2) @(negedge mclk_in);
    chk(lock_out, 1'b0, "unlock");
    lk = 1'b0;
    ll = 1'b0;
    @(posedge mclk_in);
    cpu_reset_in <= 1'b1;
    hold_in <= 1'b1;
    grant();
    @(posedge mclk_in);
    hold_in <= 1'b0;
    cpu_reset_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    $display("test hold done");
    stop_test();
  end
endmodule : ebca_bus_ctrl_test
